// ==== dv/spw_host_model.sv ====
// Behavioural SPI host for the wiper port
`timescale 1ns/10ps
`default_nettype none
module spw_host_model (
   // Host pins; sdoLine is the pulled-up data line
   output var logic sclk,
   output var logic csN,
   output var logic sdi,
   input wire logic sdoLine
);
   // Select starts low, so the first frame comes without a fall
   initial {sclk, csN, sdi} = 3'b000;
   task automatic frame(input logic [31:0] tx, input int nb, output logic [31:0] rx);
      rx = 32'h0;
      csN <= 1'b0;
      #100;
      for (int i = 8 * nb - 1; i >= 0; i--) begin
         sdi <= tx[i];
         #32 sclk <= 1'b1;
         // Sampled at the rise, before the port can react to it
         rx = {rx[30:0], sdoLine};
         #32 sclk <= 1'b0;
      end
      // Toggle so a stale bit is never mistaken for data
      sdi <= ~sdi;
      #100 csN <= 1'b1;
      #200;
   endtask
endmodule // spw_host_model
`default_nettype wire

// ==== dv/spw_pot_port_sva.sv ====
// Pin and register checker for the wiper port
`timescale 1ns/10ps
`default_nettype none
module spw_pot_port_sva #(parameter WIPER_W = 7) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic sclk,
   input wire logic csN,
   input wire logic sdoOut_ff,
   input wire logic sdoOeN_ff,
   input wire logic [WIPER_W-1:0] wiper_ff,
   input wire logic [7:0] ctlReg_ff,
   input wire logic active_ff
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   property p_rel; csN [*6] |-> sdoOeN_ff; endproperty
   a_rel: assert property (p_rel) else $error("sdo driven");
   property p_idl; csN [*6] |-> !active_ff; endproperty
   a_idl: assert property (p_idl) else $error("still active");
   property p_od; ctlReg_ff[1] && !sdoOeN_ff |-> !sdoOut_ff; endproperty
   a_od: assert property (p_od) else $error("drove high");
   property p_std; (sclk && !csN) [*6] |=> $stable(sdoOut_ff); endproperty
   a_std: assert property (p_std) else $error("sdo moved");
   property p_wip; !csN [*8] |=> $stable(wiper_ff); endproperty
   a_wip: assert property (p_wip) else $error("wiper moved");
   property p_ctl; !csN [*8] |=> $stable(ctlReg_ff); endproperty
   a_ctl: assert property (p_ctl) else $error("control moved");
   property p_arm; $rose(active_ff) |-> !$past(csN, 2); endproperty
   a_arm: assert property (p_arm) else $error("bad active");
   property p_msk; (ctlReg_ff & 8'hBD) == 8'h00; endproperty
   a_msk: assert property (p_msk) else $error("control bits");
   c_rd: cover property (!sdoOeN_ff && !sdoOut_ff);
   c_od: cover property (ctlReg_ff[1] && !sdoOeN_ff);
   c_wr: cover property ($changed(wiper_ff));
endmodule // spw_pot_port_sva
bind spw_pot_port spw_pot_port_sva #(.WIPER_W(WIPER_W)) uChk (.mclk, .rst_n, .sclk, .csN,
   .sdoOut_ff, .sdoOeN_ff, .wiper_ff, .ctlReg_ff, .active_ff);
`default_nettype wire

// ==== dv/spw_pot_port_tb.sv ====
// Bench driving frames into the wiper port
`timescale 1ns/10ps
`default_nettype none
module spw_pot_port_tb;
   logic mclk = 1'b0, rst_n = 1'b0, sdoOut_ff, sdoOeN_ff, active_ff, shutdownN_ff;
   wire logic sclk, csN, sdi;
   logic [6:0] wiper_ff;
   logic [7:0] ctlReg_ff;
   logic [31:0] rx;
   integer n_fail = 0, total_checks = 0;
   // Byte count, write frame, read command, read result
   logic [47:0] tab [7] = '{48'h0200C07F807F, 48'h03C000558000, 48'h010000C08000,
      48'h020000128000, 48'h0200C8128800, 48'h02006ABF2502, 48'h0200D0409040};
   wire logic sdoLine = sdoOeN_ff ? 1'b1 : sdoOut_ff;
   spw_pot_port #(.WIPER_W(7)) dut (.mclk, .rst_n, .sclk, .csN, .sdi, .sdoOut_ff, .sdoOeN_ff,
      .wiper_ff, .ctlReg_ff, .active_ff, .shutdownN_ff);
   spw_host_model host (.sclk, .csN, .sdi, .sdoLine);
   initial forever #2.5 mclk = ~mclk;
   task automatic chk(input string nm, input logic [7:0] seen, exp);
      total_checks++;
      n_fail += (seen !== exp);
      if (seen !== exp) $display("[ERR] %s exp %0h seen %0h", nm, exp, seen);
   endtask
   task print_verdict;
      $display("checks %0d fails %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      host.frame(32'hC011, 2, rx);
      chk("unarmed", {1'b0, wiper_ff}, 8'h40);
      $display("test unarmed done");
      for (int i = 0; i < 7; i++) begin
         host.frame({8'h0, tab[i][39:16]}, tab[i][47:40], rx);
         host.frame({tab[i][15:8], 24'h0}, 4, rx);
         chk("echo", rx[15:8], tab[i][15:8]);
         chk("data", rx[7:0], tab[i][7:0]);
         chk("shdn", {7'h0, shutdownN_ff}, {7'h0, i != 5});
         $display("test frame %0d done", i);
      end
      print_verdict;
   end
   initial begin
      #300000 n_fail++;
      print_verdict;
   end
endmodule // spw_pot_port_tb
`default_nettype wire

// ==== logic/spw_pot_port.v ====
// Serial slave port and register file of a 128-tap wiper potentiometer
//
// Contract
// - Sample data on rising clock while selected
// - Change output on falling clock during reads
// - Control bit 1 picks open-drain; reset push-pull
// - Output released whenever select is high
// - Select low means active, transfers accepted
// - Ignore traffic until first select fall
// - Select high means deselected, standby state
// - Wiper value 0 low end, 127 high
// - Command: 3-bit opcode, 5-bit register address
// - Decode no-op, control read/write, register read/write
// - Writes apply on select rising edge only
// - Read: bytes three and four echo, data
`timescale 1ns/10ps
`default_nettype none
`include "spw_regs.vh"

module spw_pot_port #(
   parameter WIPER_W = 7
) (
   // Clock and reset
   input wire mclk,
   input wire rst_n,
   // Serial pins from the host
   input wire sclk,
   input wire csN,
   input wire sdi,
   // Serial data output, two signals of a two-way pin; enable is active low
   output reg sdoOut_ff,
   output reg sdoOeN_ff,
   // Device state; the wiper value picks the tap, 0 at the low end
   output reg [WIPER_W-1:0] wiper_ff,
   // Access control register: bit 6 keeps the resistor on, bit 1 open-drain
   output reg [7:0] ctlReg_ff,
   output reg active_ff,
   output reg shutdownN_ff
);

   ////////////////////////////////////////////////////////////////////////////////
   // Two-flop synchronisers for all pins; only the second stage is read
   reg [2:0] syncA_ff;
   reg [2:0] syncB_ff;
   reg sclkOld_ff; // Previous synchronised clock, for edge finding
   reg csOld_ff; // Previous synchronised select
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         // Reset as if select were already low: a select held low through
         // reset then shows no fall and the port stays unarmed
         syncA_ff <= 3'h0;
         syncB_ff <= 3'h0;
         sclkOld_ff <= 1'b0;
         // The rise seen when a high select comes through is harmless, as
         // nothing commits before the port is armed
         csOld_ff <= 1'b0;
      end else begin
         syncA_ff <= {csN, sclk, sdi};
         syncB_ff <= syncA_ff;
         sclkOld_ff <= syncB_ff[1];
         csOld_ff <= syncB_ff[2];
      end
   end

   wire sdiS = syncB_ff[0];
   wire sclkS = syncB_ff[1];
   wire csS = syncB_ff[2];
   wire sclkRise = sclkS & ~sclkOld_ff; // Mode 0: capture edge
   wire sclkFall = ~sclkS & sclkOld_ff; // Mode 0: launch edge
   wire csFall = ~csS & csOld_ff;
   wire csRise = csS & ~csOld_ff;

   ////////////////////////////////////////////////////////////////////////////////
   // Frame state
   reg armed_ff; // Set by the first select fall after reset
   reg [2:0] bitCnt_ff; // Bit index within the current byte
   reg [2:0] byteCnt_ff; // Byte index, saturates
   reg [7:0] shift_ff; // Incoming bits, MSB first
   reg [7:0] cmd_ff; // Command byte of the frame
   reg [7:0] data_ff; // First data byte of the frame
   reg haveData_ff; // At least one data byte seen
   reg [7:0] txShift_ff; // Outgoing byte
   wire [7:0] nxt_shift = {shift_ff[6:0], sdiS}; // MSB first
   // Selected and armed: only then are clock edges counted
   wire inFrame = armed_ff & ~csS;

   // Register chosen by a command byte, zero when unmapped
   // The control-read opcode ignores the address field
   function [7:0] readReg;
      input [7:0] cmd;
      input [WIPER_W-1:0] wip;
      input [7:0] ctl;
      begin
         if (cmd[7:5] == `SPW_OP_CTL_RD)
            readReg = ctl;
         else if (cmd[4:0] == `SPW_ADDR_WIPER)
            readReg = {{(8-WIPER_W){1'b0}}, wip};
         else if (cmd[4:0] == `SPW_ADDR_CTL)
            readReg = ctl;
         else
            readReg = 8'h00;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Shifter, byte counter and command capture
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         armed_ff <= 1'b0;
         bitCnt_ff <= 3'h0;
         byteCnt_ff <= 3'h0;
         shift_ff <= 8'h00;
         cmd_ff <= 8'h00;
         data_ff <= 8'h00;
         haveData_ff <= 1'b0;
      end else if (csFall) begin
         // New frame starts clean
         armed_ff <= 1'b1;
         bitCnt_ff <= 3'h0;
         byteCnt_ff <= 3'h0;
         haveData_ff <= 1'b0;
      end else if (inFrame && sclkRise) begin
         // One bit per rising clock edge
         shift_ff <= nxt_shift;
         bitCnt_ff <= bitCnt_ff + 3'h1;
         if (bitCnt_ff == 3'h7) begin
            if (byteCnt_ff != 3'h7)
               byteCnt_ff <= byteCnt_ff + 3'h1;
            if (byteCnt_ff == 3'h0) begin
               cmd_ff <= nxt_shift;
            end else if (byteCnt_ff == 3'h1) begin
               // Only the first data byte counts for a write
               data_ff <= nxt_shift;
               haveData_ff <= 1'b1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Register file; writes commit only at the end of the frame
   // Either control-write opcode, or a register write to the control address
   wire isCtlWr = (cmd_ff[7:5] == `SPW_OP_CTL_WR) ||
      ((cmd_ff[7:5] == `SPW_OP_REG_WR) && (cmd_ff[4:0] == `SPW_ADDR_CTL));
   wire isWipWr = (cmd_ff[7:5] == `SPW_OP_REG_WR) && (cmd_ff[4:0] == `SPW_ADDR_WIPER);
   // A frame cut before its first data byte ends writes nothing
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         wiper_ff <= `SPW_WIPER_RST;
         ctlReg_ff <= `SPW_CTL_RST;
      end else if (csRise && armed_ff && haveData_ff) begin
         if (isWipWr)
            wiper_ff <= data_ff[WIPER_W-1:0];
         else if (isCtlWr) begin
            // Reserved bits always read back as zero
            ctlReg_ff <= data_ff & `SPW_CTL_WMASK;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Read path: echo in byte three, data in byte four, shifted out on falls
   wire isRead = (cmd_ff[7:5] == `SPW_OP_CTL_RD) || (cmd_ff[7:5] == `SPW_OP_REG_RD);
   wire byteStart = inFrame && sclkFall && (bitCnt_ff == 3'h0);
   // Bytes three and four of a read frame carry the answer
   wire inReadWin = (byteCnt_ff == `SPW_RD_ECHO_BYTE) || (byteCnt_ff == `SPW_RD_DATA_BYTE);
   // Open-drain only ever pulls low; a one leaves the line to the pull-up
   wire odMode = ctlReg_ff[`SPW_CTL_OD_BIT];
   // Register value, taken once as byte four opens so the byte never tears
   wire [7:0] rdVal = readReg(cmd_ff, wiper_ff, ctlReg_ff);
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         txShift_ff <= 8'h00;
         sdoOut_ff <= 1'b1;
         sdoOeN_ff <= 1'b1;
      end else if (!inFrame) begin
         // Released while deselected, in either output type
         sdoOut_ff <= 1'b1;
         sdoOeN_ff <= 1'b1;
      end else if (sclkFall) begin
         if (byteStart && isRead && inReadWin) begin
            // Load a fresh byte and launch its MSB
            if (byteCnt_ff == `SPW_RD_ECHO_BYTE) begin
               // Echo of the command byte as received
               txShift_ff <= {cmd_ff[6:0], 1'b0};
               sdoOut_ff <= cmd_ff[7];
               sdoOeN_ff <= odMode & cmd_ff[7];
            end else begin
               // MSB goes out now, the other seven wait in the shifter
               txShift_ff <= {rdVal[6:0], 1'b0};
               sdoOut_ff <= rdVal[7];
               sdoOeN_ff <= odMode & rdVal[7];
            end
         end else if (inReadWin) begin
            if (isRead && bitCnt_ff != 3'h0) begin
               // Next bit, MSB first
               txShift_ff <= {txShift_ff[6:0], 1'b0};
               sdoOut_ff <= txShift_ff[7];
               sdoOeN_ff <= odMode & txShift_ff[7];
            end
         end else begin
            sdoOut_ff <= 1'b1;
            sdoOeN_ff <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Power state outputs
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         active_ff <= 1'b0;
         shutdownN_ff <= 1'b1;
      end else begin
         // Active only while selected after the first select fall; standby otherwise
         active_ff <= inFrame;
         // Shutdown follows the control bit; the analog switches act on it elsewhere
         shutdownN_ff <= ctlReg_ff[`SPW_CTL_SHDN_BIT];
      end
   end

endmodule // spw_pot_port
`default_nettype wire

// ==== logic/spw_regs.vh ====
// Register map, field positions, reset values and frame constants of the wiper port
`ifndef SPW_REGS_VH
`define SPW_REGS_VH
// Register addresses (5-bit field of the command byte)
`define SPW_ADDR_WIPER 5'h00
`define SPW_ADDR_CTL 5'h10
// Reset values
`define SPW_WIPER_RST 7'h40
`define SPW_CTL_RST 8'h40
// Access control register fields
`define SPW_CTL_OD_BIT 1
`define SPW_CTL_SHDN_BIT 6
`define SPW_CTL_WMASK 8'h42
// Instruction codes (top three bits)
`define SPW_OP_NOOP 3'h0
`define SPW_OP_CTL_RD 3'h1
`define SPW_OP_CTL_WR 3'h3
`define SPW_OP_REG_RD 3'h4
`define SPW_OP_REG_WR 3'h6
// Byte position of the read echo and read data in a frame
`define SPW_RD_ECHO_BYTE 3'h2
`define SPW_RD_DATA_BYTE 3'h3
`endif
